// *** bench/spi_transfer_format_timing_tb.sv ***
// Purpose: Both ends joined; AXI side and far user side driven
// Assumes: Far end keeps its own half bit of eight cycles
// Notes:   Start delay, first bit and idle level judged on the wires
`timescale 1ns/100ps
`include "sxf_params.svh"
module spi_transfer_format_timing_tb;
	logic        core_clk_i = 1'b0, rst_n_i = 1'b0, s0;
	logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_val;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
	logic        mst_i = 1'b0, clock_polarity_bit_i = 1'b0, clock_phase_bit_i = 1'b0, start_i = 1'b0;
	logic        busy_o, rx_valid_o;
	logic [7:0]  tx_i = 8'h00, rx_o, far_last;
	int          failures = 0, n_checks = 0, far_cnt = 0;
	sxf_link_if  link();
	always #12.5 core_clk_i = ~core_clk_i;
	sxf_dev u_sxf_dev (.*);
	sxf_far u_sxf_far (.*);
	sxf_checker u_sxf_checker (.core_clk_i, .rst_n_i, .dev_sck_o(link.dev_sck_o),
		.dev_sck_oe(link.dev_sck_oe), .dev_mosi_oe(link.dev_mosi_oe),
		.dev_miso_oe(link.dev_miso_oe), .dev_sel_n(link.dev_sel_n),
		.far_sck_oe(link.far_sck_oe), .far_sel_n(link.far_sel_n));
	// Last byte taken in by the far end
	always @(posedge core_clk_i) begin
		if (rx_valid_o === 1'b1) begin
			far_last <= rx_o;
			far_cnt  <= far_cnt + 1;
		end
	end
	task automatic give_verdict();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// A bounded wait ran out
	task automatic tmo(input string nm);
		chk(nm, 32'h1, 32'h0);
		give_verdict();
	endtask : tmo
	// One AXI write (w high) or read; answer lands in resp and rd_val
	task automatic bus(input bit w, input logic [3:0] a, input logic [31:0] d);
		int k;
		@(posedge core_clk_i);
		s_axi_awaddr  <= a;
		s_axi_araddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= w;
		s_axi_wvalid  <= w;
		s_axi_arvalid <= !w;
		s_axi_bready  <= w;
		s_axi_rready  <= !w;
		for (k = 0; k < 50; k++) begin
			@(posedge core_clk_i);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if ((s_axi_bready && s_axi_bvalid) || (s_axi_rready && s_axi_rvalid)) break;
		end
		if (k == 50) tmo("bus answer");
		resp   = w ? s_axi_bresp : s_axi_rresp;
		rd_val = s_axi_rdata;
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
	endtask : bus
	function automatic logic [31:0] ctl(input int rt, input bit pol, pha, ms);
		return 32'(rt) << `SXF_CTRL_RATE_LO | 32'(pha) << `SXF_CTRL_CLOCK_PHASE_BIT
			| 32'(pol) << `SXF_CTRL_CLOCK_POLARITY_BIT | 32'(ms) << `SXF_CTRL_MST | 32'h1;
	endfunction : ctl
	// Device master, far slave, one byte each way
	task automatic t_master(input int rt, input bit pol, pha, input logic [7:0] a, b);
		int n;
		int m;
		bus(1, `SXF_ADDR_CTRL, 32'h0);
		mst_i  <= 1'b0;
		clock_polarity_bit_i <= pol;
		clock_phase_bit_i <= pha;
		tx_i   <= b;
		bus(1, `SXF_ADDR_CTRL, ctl(rt, pol, pha, 1));
		@(posedge core_clk_i);
		s0 = link.sck;
		chk("idle level", {31'h0, pol}, {31'h0, s0});
		bus(1, `SXF_ADDR_DATA, {24'h0, a});
		for (n = 0; n < 300 && link.dev_sel_n; n++) @(posedge core_clk_i);
		chk("start delay", 32'h1, {31'h0, n <= (2 << 2 * rt)});
		for (m = 0; m < 300 && link.sck === s0; m++) @(posedge core_clk_i);
		chk("first half bit", {31'h0, !pha}, {31'h0, m != 0});
		chk("first bit", {31'h0, a[7]}, {31'h0, link.mosi});
		for (n = 0; n < 3000 && !link.dev_sel_n; n++) @(posedge core_clk_i);
		if (n == 3000) tmo("frame end");
		chk("idle after", {31'h0, pol}, {31'h0, link.sck});
		bus(0, `SXF_ADDR_DATA, 32'h0);
		// Both ends synchronise, some six cycles round trip: master-in
		// data can only hold at the two slow rates
		if (rt >= 2) chk("master rx", {24'h0, b}, rd_val);
		chk("far rx", {24'h0, a}, {24'h0, far_last});
	endtask : t_master
	// Far master sends t; with late set, e is written mid frame
	task automatic far_xfer(input logic [7:0] t, input bit late, input logic [7:0] e);
		int k;
		int c0;
		c0 = far_cnt;
		tx_i    <= t;
		start_i <= 1'b1;
		@(posedge core_clk_i);
		start_i <= 1'b0;
		if (late) begin
			repeat (20) @(posedge core_clk_i);
			bus(1, `SXF_ADDR_DATA, {24'h0, e});
		end
		for (k = 0; k < 400 && (far_cnt == c0 || busy_o); k++) @(posedge core_clk_i);
		if (k == 400) tmo("far frame");
	endtask : far_xfer
	// Device slave; a late write must wait for the next frame
	task automatic t_slave(input bit pol, pha, input logic [7:0] c, d, e);
		bus(1, `SXF_ADDR_CTRL, 32'h0);
		mst_i  <= 1'b1;
		clock_polarity_bit_i <= pol;
		clock_phase_bit_i <= pha;
		bus(1, `SXF_ADDR_CTRL, ctl(0, pol, pha, 0));
		bus(1, `SXF_ADDR_DATA, {24'h0, c});
		far_xfer(d, 1, e);
		chk("far rx", {24'h0, c}, {24'h0, far_last});
		bus(0, `SXF_ADDR_DATA, 32'h0);
		chk("slave rx", {24'h0, d}, rd_val);
		far_xfer(8'h00, 0, 8'h00);
		chk("far rx next", {24'h0, e}, {24'h0, far_last});
	endtask : t_slave
	initial begin
		int i;
		repeat (10) @(posedge core_clk_i);
		rst_n_i <= 1'b1;
		bus(0, `SXF_ADDR_CTRL, 32'h0);
		chk("ctrl reset", 32'h0, rd_val);
		bus(0, 4'hc, 32'h0);
		chk("unmapped", {30'h0, `SXF_RESP_SLVERR}, {30'h0, resp});
		bus(1, 4'hc, 32'h0);
		chk("unmapped write", {30'h0, `SXF_RESP_SLVERR}, {30'h0, resp});
		bus(0, `SXF_ADDR_STAT, 32'h0);
		chk("status reset", 32'h1, rd_val);
		for (i = 0; i < 4; i++) t_master(i, i[0], i[1], 8'ha5 ^ 8'(i), 8'h3c + 8'(i));
		t_master(2, 1'b1, 1'b0, 8'h96, 8'h69);
		t_slave(1'b0, 1'b0, 8'h81, 8'h5a, 8'hc3);
		t_slave(1'b1, 1'b1, 8'h7e, 8'h18, 8'h24);
		give_verdict();
	end
endmodule : spi_transfer_format_timing_tb

// *** bench/sxf_checker.sv ***
// Purpose: Wire checks on the serial link between both ends
// Assumes: Bench never makes both ends master at once
// Notes:   Helper counter tracks clock edges per frame
`timescale 1ns/100ps
module sxf_checker (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic dev_sck_o,
	input wire logic dev_sck_oe,
	input wire logic dev_mosi_oe,
	input wire logic dev_miso_oe,
	input wire logic dev_sel_n,
	input wire logic far_sck_oe,
	input wire logic far_sel_n
);
	logic [4:0] edge_ff, nxt_edge; // Edges in this frame
	logic       sck_ff;            // Clock one cycle back
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	// Edge count, cleared while deselected
	always_comb begin
		nxt_edge = dev_sel_n ? 5'h00 : edge_ff + {4'h0, dev_sck_o ^ sck_ff};
	end
	// Registers only
	always_ff @(posedge core_clk_i) begin
		edge_ff <= rst_n_i ? nxt_edge : 5'h00;
		sck_ff  <= dev_sck_o;
	end
	a_frame_edges: assert property ($rose(dev_sel_n) |-> edge_ff == 5'h10)
		else $error("frame without sixteen edges");
	a_sel_gap: assert property ($rose(dev_sel_n) |=> dev_sel_n)
		else $error("select high too short");
	a_master_drives: assert property (!dev_sel_n |-> dev_sck_oe && dev_mosi_oe)
		else $error("master frame without drivers");
	a_no_clash: assert property (!(dev_sck_oe && far_sck_oe))
		else $error("two clock drivers");
	a_idle_still: assert property (dev_sel_n && $past(dev_sel_n) && dev_sck_oe &&
		$past(dev_sck_oe) |-> $stable(dev_sck_o)) else $error("clock moved outside frame");
	a_first_edge: assert property ($fell(dev_sel_n) |-> ##[0:65] $changed(dev_sck_o))
		else $error("no clock edge in first bit");
	a_miso_on: assert property ($fell(far_sel_n) |-> ##[1:4] dev_miso_oe)
		else $error("slave not driving after select");
	a_miso_off: assert property ($rose(far_sel_n) |-> ##[1:4] !dev_miso_oe)
		else $error("slave still driving");
	a_miso_sel: assert property (dev_miso_oe |-> !$past(far_sel_n, 2) ||
		!$past(far_sel_n, 3)) else $error("slave drives unselected");
endmodule : sxf_checker

// *** rtl/sxf_dev.sv ***
// Purpose: Serial transfer engine, master or slave, with AXI4-Lite registers
// Assumes: One bus clock, pins from the far end synchronised here
// Notes:   Eight-bit transfers, MSB first, full duplex
// Behaviour
// - Polarity sets only clock idle level
// - Phase picks one of two framings
// - Software disables module before changing format
// - Both ends share phase and polarity
// - Slave drives output only while selected
// - Master select input held high or unused
// - Phase zero: first edge samples MSB
// - Phase zero: master toggles select per byte
// - Phase zero slave: select fall starts, locks
// - Phase zero: late write waits for end
// - Phase one: first clock edge starts transfer
// - Phase one: select may stay low
// - Phase one slave: first edge drives MSB
// - Phase one: late write waits for end
// - Master data write starts, phase-independent delay
// - Master first half-bit shape by phase
// - Master clock runs only enabled master
// - Clock edges placed on bus clock
// - Start delay within one bit time
// - Master select bit picks master/slave
// - Rate field picks one of four dividers
//
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`include "sxf_params.svh"
module sxf_dev
	import sxf_pkg::*;
(
	input  wire logic        core_clk_i,     // Bus clock, 40 MHz
	input  wire logic        rst_n_i,        // Synchronous reset, low
	input  wire logic [3:0]  s_axi_awaddr,   // Write address
	input  wire logic        s_axi_awvalid,  // Write address valid
	output logic             s_axi_awready,  // Write address ready
	input  wire logic [31:0] s_axi_wdata,    // Write data
	input  wire logic [3:0]  s_axi_wstrb,    // Write strobes
	input  wire logic        s_axi_wvalid,   // Write data valid
	output logic             s_axi_wready,   // Write data ready
	output logic [1:0]       s_axi_bresp,    // Write response
	output logic             s_axi_bvalid,   // Write response valid
	input  wire logic        s_axi_bready,   // Write response ready
	input  wire logic [3:0]  s_axi_araddr,   // Read address
	input  wire logic        s_axi_arvalid,  // Read address valid
	output logic             s_axi_arready,  // Read address ready
	output logic [31:0]      s_axi_rdata,    // Read data
	output logic [1:0]       s_axi_rresp,    // Read response
	output logic             s_axi_rvalid,   // Read data valid
	input  wire logic        s_axi_rready,   // Read data ready
	sxf_link_if.dev          link            // Pins
);
	// Bus slave state
	logic        aw_got_ff, nxt_aw_got;      // Write address held
	logic [3:0]  aw_addr_ff, nxt_aw_addr;    // Held write address
	logic        w_got_ff, nxt_w_got;        // Write data held
	logic [31:0] w_data_ff, nxt_w_data;      // Held write data
	logic        w_lo_ff, nxt_w_lo;          // Low byte lane strobed
	logic        bvalid_ff, nxt_bvalid;      // Write answer pending
	logic [1:0]  bresp_ff, nxt_bresp;        // Write answer code
	logic        rvalid_ff, nxt_rvalid;      // Read answer pending
	logic [31:0] rdata_ff, nxt_rdata;        // Read answer data
	logic [1:0]  rresp_ff, nxt_rresp;        // Read answer code
	// Transfer state
	logic [5:0]  ctrl_ff, nxt_ctrl;          // Control register
	logic [7:0]  tx_buf_ff, nxt_tx_buf;      // Transmit data register
	logic        tx_full_ff, nxt_tx_full;    // Transmit register holds a byte
	logic [7:0]  rx_ff, nxt_rx;              // Receive data register
	logic        rx_full_ff, nxt_rx_full;    // Receive register unread
	sxf_state_t  st_ff, nxt_st;              // Transfer state
	logic [7:0]  sh_ff, nxt_sh;              // Shift register
	logic        samp_ff, nxt_samp;          // Bit caught on sample edge
	logic [3:0]  ecnt_ff, nxt_ecnt;          // Clock edge counter
	logic        act_ff, nxt_act;            // Master clock at active level
	logic [6:0]  div_ff, nxt_div;            // Free-running divider
	logic        sel_n_ff, nxt_sel_n;        // Master select output
	// Pin synchronisers
	logic [2:0]  sck_s, ss_s;                // Third flop only for edges
	logic [1:0]  mosi_s, miso_s;             // Data inputs
	// Decoded controls
	logic        en, mst, clock_polarity_bit, clock_phase_bit, do_wr, rd_hit, tick, ev, bit_in, samp_edge;
	logic [6:0]  half;
	logic [31:0] rd_mux;

	// Two flops before any logic reads a pin
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			sck_s  <= 3'h7;
			ss_s   <= 3'h7;
			mosi_s <= 2'h3;
			miso_s <= 2'h3;
		end else begin
			sck_s  <= {sck_s[1:0], link.sck};
			ss_s   <= {ss_s[1:0], link.far_sel_n};
			mosi_s <= {mosi_s[0], link.mosi};
			miso_s <= {miso_s[0], link.miso};
		end
	end

	// Control fields
	assign en   = ctrl_ff[`SXF_CTRL_EN];
	assign mst  = ctrl_ff[`SXF_CTRL_MST];
	// One format pair serves both roles
	assign clock_polarity_bit = ctrl_ff[`SXF_CTRL_CLOCK_POLARITY_BIT];
	assign clock_phase_bit = ctrl_ff[`SXF_CTRL_CLOCK_PHASE_BIT];

	// Read mux, zero in unused bits
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (s_axi_araddr)
			`SXF_ADDR_CTRL: rd_mux[5:0] = ctrl_ff;
			`SXF_ADDR_DATA: rd_mux[7:0] = rx_ff;
			`SXF_ADDR_STAT: begin
				rd_mux[`SXF_STAT_TXE]  = !tx_full_ff;
				rd_mux[`SXF_STAT_RXF]  = rx_full_ff;
				rd_mux[`SXF_STAT_BUSY] = (st_ff != st_idle);
			end
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Bus slave next state; address and data taken in either order
	always_comb begin
		nxt_aw_got = aw_got_ff;
		nxt_aw_addr = aw_addr_ff;
		nxt_w_got = w_got_ff;
		nxt_w_data = w_data_ff;
		nxt_w_lo = w_lo_ff;
		nxt_bvalid = bvalid_ff;
		nxt_bresp = bresp_ff;
		nxt_rvalid = rvalid_ff;
		nxt_rdata = rdata_ff;
		nxt_rresp = rresp_ff;
		rd_hit = 1'b0;
		do_wr = aw_got_ff && w_got_ff && !bvalid_ff;
		if (s_axi_awvalid && s_axi_awready) begin
			nxt_aw_got = 1'b1;
			nxt_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			nxt_w_got = 1'b1;
			nxt_w_data = s_axi_wdata;
			nxt_w_lo = s_axi_wstrb[0];
		end
		// Commit one cycle after both halves are held
		if (do_wr) begin
			nxt_aw_got = 1'b0;
			nxt_w_got = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp = (aw_addr_ff == `SXF_ADDR_CTRL || aw_addr_ff == `SXF_ADDR_DATA
				|| aw_addr_ff == `SXF_ADDR_STAT) ? `SXF_RESP_OKAY : `SXF_RESP_SLVERR;
		end else if (bvalid_ff && s_axi_bready) begin
			nxt_bvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			nxt_rvalid = 1'b1;
			nxt_rdata = rd_mux;
			nxt_rresp = (s_axi_araddr == `SXF_ADDR_CTRL || s_axi_araddr == `SXF_ADDR_DATA
				|| s_axi_araddr == `SXF_ADDR_STAT) ? `SXF_RESP_OKAY : `SXF_RESP_SLVERR;
			rd_hit = (s_axi_araddr == `SXF_ADDR_DATA);
		end else if (rvalid_ff && s_axi_rready) begin
			nxt_rvalid = 1'b0;
		end
	end

	// Rate field to half bit count
	always_comb begin
		case (sxf_rate_t'(ctrl_ff[`SXF_CTRL_RATE_HI:`SXF_CTRL_RATE_LO]))
			rate_divide_by_two:            half = `SXF_HALF_RATE_DIVIDE_BY_TWO;
			rate_divide_by_eight:          half = `SXF_HALF_RATE_DIVIDE_BY_EIGHT;
			rate_divide_by_thirtytwo:      half = `SXF_HALF_RATE_DIVIDE_BY_THIRTYTWO;
			rate_divide_by_onetwentyeight: half = `SXF_HALF_RATE_DIVIDE_BY_ONETWENTYEIGHT;
			default:                       half = `SXF_HALF_RATE_DIVIDE_BY_TWO;
		endcase
	end

	// Transfer engine next state
	always_comb begin
		nxt_ctrl = ctrl_ff;
		nxt_tx_buf = tx_buf_ff;
		nxt_tx_full = tx_full_ff;
		nxt_rx = rx_ff;
		nxt_rx_full = rx_full_ff;
		nxt_st = st_ff;
		nxt_sh = sh_ff;
		nxt_samp = samp_ff;
		nxt_ecnt = ecnt_ff;
		nxt_act = act_ff;
		nxt_sel_n = sel_n_ff;
		// Divider runs only as enabled master
		tick = en && mst && (div_ff == half - 7'h01);
		nxt_div = (en && mst && !tick) ? div_ff + 7'h01 : 7'h00;
		// Edges land on bus clock, one tick per half bit
		ev = (st_ff == st_xfer) && (mst ? tick : ((sck_s[2] ^ sck_s[1]) && !ss_s[1]));
		bit_in = mst ? miso_s[1] : mosi_s[1];
		samp_edge = (ecnt_ff[0] == clock_phase_bit);
		case (st_ff)
			st_idle: begin
				// Start at next tick, same for either phase
				// Wait at most half a bit time
				if (en && mst && tx_full_ff && tick) begin
					nxt_st = st_xfer;
					nxt_sh = tx_buf_ff;
					nxt_tx_full = 1'b0;
					nxt_sel_n = 1'b0;
					// Phase one opens with a leading edge
					nxt_act = clock_phase_bit;
					nxt_ecnt = clock_phase_bit ? 4'h1 : 4'h0;
				// Select fall starts, MSB out at once
				end else if (en && !mst && !clock_phase_bit && ss_s[2] && !ss_s[1]) begin
					nxt_st = st_xfer;
					nxt_sh = tx_full_ff ? tx_buf_ff : sh_ff;
					nxt_tx_full = 1'b0;
					nxt_ecnt = 4'h0;
				// Select may stay low between bytes
				// First edge leaving idle starts transfer
				end else if (en && !mst && clock_phase_bit && !ss_s[1] && (sck_s[2] == clock_polarity_bit)
					&& (sck_s[1] != clock_polarity_bit)) begin
					nxt_st = st_xfer;
					nxt_sh = tx_full_ff ? tx_buf_ff : sh_ff;
					nxt_tx_full = 1'b0;
					nxt_ecnt = 4'h1;
				end
			end
			st_xfer: begin
				// Select lost mid-byte: abandon, ignore the clock
				if (!mst && ss_s[1]) begin
					nxt_st = st_idle;
				end else if (ev) begin
					nxt_act = mst ? !act_ff : act_ff;
					nxt_ecnt = ecnt_ff + 4'h1;
					if (samp_edge) begin
						nxt_samp = bit_in;
					// Drive edges shift next bit out
					end else if (ecnt_ff != 4'h0) begin
						nxt_sh = {sh_ff[6:0], samp_ff};
					end
					if (ecnt_ff == `SXF_LAST_EDGE) begin
						nxt_rx = {sh_ff[6:0], clock_phase_bit ? bit_in : samp_ff};
						nxt_rx_full = 1'b1;
						nxt_st = (mst || !clock_phase_bit) ? st_done : st_idle;
					end
				end
			end
			// Master keeps select low half a bit past the last edge, so a
			// synchronising slave sees that edge before select rises
			// Phase zero slave waits for select high
			st_done: begin
				if (mst && tick) begin
					nxt_sel_n = 1'b1;
					nxt_st = st_idle;
				end else if (!mst && ss_s[1]) begin
					nxt_st = st_idle;
				end
			end
			default: nxt_st = st_idle;
		endcase
		// Disabling drops any transfer
		if (!en) begin
			nxt_st = st_idle;
			nxt_act = 1'b0;
			nxt_sel_n = 1'b1;
		end
		// Data read clears receive flag; a new byte wins
		if (rd_hit && !(ev && ecnt_ff == `SXF_LAST_EDGE)) begin
			nxt_rx_full = 1'b0;
		end
		// Register writes; format bits follow any control write with the low byte lane strobed, enabled or not
		if (do_wr && w_lo_ff && aw_addr_ff == `SXF_ADDR_CTRL) begin
			nxt_ctrl = w_data_ff[5:0];
		end
		// Late write held until byte ends
		// Shift register loads only at start
		if (do_wr && w_lo_ff && aw_addr_ff == `SXF_ADDR_DATA) begin
			nxt_tx_buf = w_data_ff[7:0];
			nxt_tx_full = 1'b1;
		end
	end

	// All registers of the block except the pin synchronisers
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			aw_got_ff <= 1'b0;
			aw_addr_ff <= 4'h0;
			w_got_ff <= 1'b0;
			w_data_ff <= 32'h0000_0000;
			w_lo_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= 2'h0;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= 2'h0;
			ctrl_ff <= `SXF_CTRL_RST;
			tx_buf_ff <= 8'h00;
			tx_full_ff <= 1'b0;
			rx_ff <= 8'h00;
			rx_full_ff <= 1'b0;
			st_ff <= st_idle;
			sh_ff <= 8'h00;
			samp_ff <= 1'b0;
			ecnt_ff <= 4'h0;
			act_ff <= 1'b0;
			div_ff <= 7'h00;
			sel_n_ff <= 1'b1;
		end else begin
			aw_got_ff <= nxt_aw_got;
			aw_addr_ff <= nxt_aw_addr;
			w_got_ff <= nxt_w_got;
			w_data_ff <= nxt_w_data;
			w_lo_ff <= nxt_w_lo;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			rvalid_ff <= nxt_rvalid;
			rdata_ff <= nxt_rdata;
			rresp_ff <= nxt_rresp;
			ctrl_ff <= nxt_ctrl;
			tx_buf_ff <= nxt_tx_buf;
			tx_full_ff <= nxt_tx_full;
			rx_ff <= nxt_rx;
			rx_full_ff <= nxt_rx_full;
			st_ff <= nxt_st;
			sh_ff <= nxt_sh;
			samp_ff <= nxt_samp;
			ecnt_ff <= nxt_ecnt;
			act_ff <= nxt_act;
			div_ff <= nxt_div;
			sel_n_ff <= nxt_sel_n;
		end
	end

	// Bus handshakes; one write and one read in flight
	assign s_axi_awready = !aw_got_ff && !bvalid_ff;
	assign s_axi_wready  = !w_got_ff && !bvalid_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = !rvalid_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;

	// Polarity only flips the clock level
	assign link.dev_sck_o   = clock_polarity_bit ^ act_ff;
	assign link.dev_sck_oe  = en && mst;
	assign link.dev_mosi_o  = sh_ff[7];
	assign link.dev_mosi_oe = en && mst;
	assign link.dev_miso_o  = sh_ff[7];
	assign link.dev_miso_oe = en && !mst && !ss_s[1];
	assign link.dev_sel_n   = sel_n_ff;
endmodule : sxf_dev

// *** rtl/sxf_far.sv ***
// Purpose: Remote master or slave at the far end of the serial link
// Assumes: Mode and format inputs held steady while busy
// Notes:   User side is a start strobe with a byte and a received-byte strobe
`timescale 1ns/100ps
`include "sxf_params.svh"
module sxf_far
	import sxf_pkg::*;
(
	input  wire logic       core_clk_i,  // Bus clock
	input  wire logic       rst_n_i,     // Synchronous reset, low
	sxf_link_if.far         link,        // Pins
	input  wire logic       mst_i,       // Act as master
	input  wire logic       clock_polarity_bit_i,      // Idle clock level
	input  wire logic       clock_phase_bit_i,      // Phase format
	input  wire logic       start_i,     // Master: start a byte
	input  wire logic [7:0] tx_i,        // Byte to send
	output logic            busy_o,      // Transfer under way
	output logic      [7:0] rx_o,        // Last byte received
	output logic            rx_valid_o   // One-cycle strobe with rx_o
);
	sxf_state_t st_ff, nxt_st;            // Transfer state
	logic [7:0] sh_ff, nxt_sh;            // Shift register
	logic       samp_ff, nxt_samp;        // Sampled bit
	logic [3:0] ecnt_ff, nxt_ecnt;        // Edge counter
	logic       act_ff, nxt_act;          // Clock at active level
	logic [6:0] div_ff, nxt_div;          // Half bit divider
	logic       sel_n_ff, nxt_sel_n;      // Select to device
	logic [7:0] rx_ff, nxt_rx;            // Received byte
	logic       rxv_ff, nxt_rxv;          // Received strobe
	logic [2:0] sck_s, sel_s;             // Pin synchronisers
	logic [1:0] mosi_s, miso_s;           // Data synchronisers
	logic       tick, ev, bit_in, samp_edge;

	// Two flops before any logic reads a pin
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			sck_s  <= 3'h7;
			sel_s  <= 3'h7;
			mosi_s <= 2'h3;
			miso_s <= 2'h3;
		end else begin
			sck_s  <= {sck_s[1:0], link.sck};
			sel_s  <= {sel_s[1:0], link.dev_sel_n};
			mosi_s <= {mosi_s[0], link.mosi};
			miso_s <= {miso_s[0], link.miso};
		end
	end

	// Next state of the transfer
	always_comb begin
		nxt_st = st_ff;
		nxt_sh = sh_ff;
		nxt_samp = samp_ff;
		nxt_ecnt = ecnt_ff;
		nxt_act = act_ff;
		nxt_sel_n = sel_n_ff;
		nxt_rx = rx_ff;
		nxt_rxv = 1'b0;
		tick = mst_i && (st_ff != st_idle) && (div_ff == `SXF_FAR_HALF - 7'h01);
		nxt_div = (tick || st_ff == st_idle) ? 7'h00 : div_ff + 7'h01;
		ev = mst_i ? (tick && st_ff == st_xfer)
			: (st_ff == st_xfer && (sck_s[2] ^ sck_s[1]) && !sel_s[1]);
		bit_in = mst_i ? miso_s[1] : mosi_s[1];
		samp_edge = (ecnt_ff[0] == clock_phase_bit_i);
		case (st_ff)
			st_idle: begin
				// Master start, select low first
				if (mst_i && start_i) begin
					nxt_st = st_xfer;
					nxt_sh = tx_i;
					nxt_ecnt = 4'h0;
					nxt_sel_n = 1'b0;
				end else if (!mst_i && !clock_phase_bit_i && sel_s[2] && !sel_s[1]) begin
					nxt_st = st_xfer;
					nxt_sh = tx_i;
					nxt_ecnt = 4'h0;
				end else if (!mst_i && clock_phase_bit_i && !sel_s[1] && (sck_s[1] != clock_polarity_bit_i)
					&& (sck_s[2] == clock_polarity_bit_i)) begin
					// First edge already consumed
					nxt_st = st_xfer;
					nxt_sh = tx_i;
					nxt_ecnt = 4'h1;
				end
			end
			st_xfer: begin
				if (!mst_i && sel_s[1]) begin
					nxt_st = st_idle;
				end else if (ev) begin
					nxt_act = mst_i ? !act_ff : act_ff;
					nxt_ecnt = ecnt_ff + 4'h1;
					if (samp_edge) begin
						nxt_samp = bit_in;
					end else if (ecnt_ff != 4'h0) begin
						nxt_sh = {sh_ff[6:0], samp_ff};
					end
					if (ecnt_ff == `SXF_LAST_EDGE) begin
						nxt_rx = {sh_ff[6:0], clock_phase_bit_i ? bit_in : samp_ff};
						nxt_rxv = 1'b1;
						nxt_st = mst_i ? st_done : st_idle;
					end
				end
			end
			st_done: begin
				if (tick) begin
					nxt_sel_n = 1'b1;
					nxt_st = st_idle;
				end
			end
			default: nxt_st = st_idle;
		endcase
	end

	// State registers
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			st_ff <= st_idle;
			sh_ff <= 8'h00;
			samp_ff <= 1'b0;
			ecnt_ff <= 4'h0;
			act_ff <= 1'b0;
			div_ff <= 7'h00;
			sel_n_ff <= 1'b1;
			rx_ff <= 8'h00;
			rxv_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			sh_ff <= nxt_sh;
			samp_ff <= nxt_samp;
			ecnt_ff <= nxt_ecnt;
			act_ff <= nxt_act;
			div_ff <= nxt_div;
			sel_n_ff <= nxt_sel_n;
			rx_ff <= nxt_rx;
			rxv_ff <= nxt_rxv;
		end
	end

	// Pins and user outputs
	assign link.far_sck_o   = clock_polarity_bit_i ^ act_ff;
	assign link.far_sck_oe  = mst_i;
	assign link.far_mosi_o  = sh_ff[7];
	assign link.far_mosi_oe = mst_i;
	assign link.far_miso_o  = sh_ff[7];
	assign link.far_miso_oe = !mst_i && !sel_s[1];
	assign link.far_sel_n   = mst_i ? sel_n_ff : 1'b1;
	assign busy_o     = (st_ff != st_idle);
	assign rx_o       = rx_ff;
	assign rx_valid_o = rxv_ff;
endmodule : sxf_far

// *** rtl/sxf_link_if.sv ***
// Purpose: Serial clock, data and select wires between device end and far end
// Assumes: Undriven wires are pulled high
// Notes:   Each two-way pin is resolved here from the enables
`timescale 1ns/100ps
interface sxf_link_if;
	logic dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe, dev_miso_o, dev_miso_oe;
	logic far_sck_o, far_sck_oe, far_mosi_o, far_mosi_oe, far_miso_o, far_miso_oe;
	logic dev_sel_n;   // Select from device master to far slave
	logic far_sel_n;   // Select from far master to device slave
	logic sck;         // Resolved serial clock
	logic mosi;        // Resolved master out line
	logic miso;        // Resolved master in line
	// Pull-up when nobody drives
	assign sck  = dev_sck_oe ? dev_sck_o : (far_sck_oe ? far_sck_o : 1'b1);
	assign mosi = dev_mosi_oe ? dev_mosi_o : (far_mosi_oe ? far_mosi_o : 1'b1);
	assign miso = dev_miso_oe ? dev_miso_o : (far_miso_oe ? far_miso_o : 1'b1);
	modport dev (output dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe, dev_miso_o,
		dev_miso_oe, dev_sel_n, input sck, mosi, miso, far_sel_n);
	modport far (output far_sck_o, far_sck_oe, far_mosi_o, far_mosi_oe, far_miso_o,
		far_miso_oe, far_sel_n, input sck, mosi, miso, dev_sel_n);
endinterface : sxf_link_if

// *** rtl/sxf_params.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the serial link
// Assumes: 32-bit register words on AXI4-Lite, 4-bit byte address
// Notes:   Definitions only
`ifndef SXF_PARAMS_SVH
`define SXF_PARAMS_SVH
// Register byte offsets
`define SXF_ADDR_CTRL   4'h0
`define SXF_ADDR_DATA   4'h4
`define SXF_ADDR_STAT   4'h8
// Control field positions
`define SXF_CTRL_EN     0
`define SXF_CTRL_MST    1
`define SXF_CTRL_CLOCK_POLARITY_BIT   2
`define SXF_CTRL_CLOCK_PHASE_BIT   3
`define SXF_CTRL_RATE_LO 4
`define SXF_CTRL_RATE_HI 5
`define SXF_CTRL_RST    6'h00
// Status field positions
`define SXF_STAT_TXE    0
`define SXF_STAT_RXF    1
`define SXF_STAT_BUSY   2
// Half bit time in bus cycles: bit times 2, 8, 32, 128
`define SXF_HALF_RATE_DIVIDE_BY_TWO   7'h01
`define SXF_HALF_RATE_DIVIDE_BY_EIGHT   7'h04
`define SXF_HALF_RATE_DIVIDE_BY_THIRTYTWO  7'h10
`define SXF_HALF_RATE_DIVIDE_BY_ONETWENTYEIGHT 7'h40
// Last of the sixteen clock edges of a byte
`define SXF_LAST_EDGE   4'hf
// Half bit time of the far end when it is master; must cover the
// round trip through both ends' synchronisers
`define SXF_FAR_HALF    7'h08
// AXI responses
`define SXF_RESP_OKAY   2'h0
`define SXF_RESP_SLVERR 2'h2
`endif

// *** rtl/sxf_pkg.sv ***
// Purpose: Types shared by both ends of the serial link
// Assumes: Constants live in sxf_params.svh
// Notes:   Rate codes follow the control rate field
package sxf_pkg;
	// Rate field codes, slowest last
	typedef enum logic [1:0] {
		rate_divide_by_two,
		rate_divide_by_eight,
		rate_divide_by_thirtytwo,
		rate_divide_by_onetwentyeight
	} sxf_rate_t;
	// Transfer state of either end
	typedef enum logic [1:0] {
		st_idle,
		st_xfer,
		st_done
	} sxf_state_t;
endpackage : sxf_pkg
